// file: common/cng_pkg.sv
package cng_pkg;

  // ----------------------------------------------------------------
  // Register indices on the management port
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_BASIC_CONTROL  = 5'h00;
  localparam logic [4:0] REG_BASIC_STATUS   = 5'h01;
  localparam logic [4:0] REG_NEG_ADVERT     = 5'h04;
  localparam logic [4:0] REG_PARTNER_BASE   = 5'h05;
  localparam logic [4:0] REG_NEG_EXPANSION  = 5'h06;
  localparam logic [4:0] REG_NEXT_PAGE_TX   = 5'h07;
  localparam logic [4:0] REG_PARTNER_NEXT   = 5'h08;
  localparam logic [4:0] REG_GIGABIT_CTRL   = 5'h09;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ADV_SELECTOR_LSB   = 0;
  localparam int ADV_SELECTOR_MSB   = 4;
  localparam int ADV_TECH_LSB       = 5;
  localparam int ADV_TECH_MSB       = 12;
  localparam int ADV_NEXT_PAGE_BIT  = 15;
  localparam int GIG_TEST_LSB       = 13;
  localparam int GIG_TEST_MSB       = 15;
  localparam int GIG_MANUAL_EN_BIT  = 12;
  localparam int GIG_MANUAL_VAL_BIT = 11;
  localparam int GIG_PORT_TYPE_BIT  = 10;
  localparam int GIG_FULL_BIT       = 9;
  localparam int GIG_HALF_BIT       = 8;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] ADV_RESET       = 16'h8000;
  localparam logic [15:0] ADV_WR_MASK     = 16'h7FFF;
  localparam logic [15:0] ADV_FORCE_ONE   = 16'h8000;
  localparam logic [15:0] NPT_RESET       = 16'h0000;
  localparam logic [15:0] NPT_WR_MASK     = 16'hFFFF;
  localparam logic [15:0] GIG_RESET       = 16'h0000;
  localparam logic [15:0] GIG_WR_MASK     = 16'hFF00;
  localparam logic [15:0] PARTNER_RESET   = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ   = 16'h0000;

endpackage : cng_pkg

// file: rtl/cng_field_reg.sv
`timescale 1ns/1ns
// Masked management register: only bits set in WR_MASK take written data
module cng_field_reg #(
  parameter int          WIDTH   = 16,
  parameter logic [15:0] RESET   = 16'h0000,
  parameter logic [15:0] WR_MASK = 16'hFFFF,
  parameter logic [15:0] FORCE   = 16'h0000
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             wrEn,
  input  wire logic [WIDTH-1:0] wrData,
  output logic      [WIDTH-1:0] value,
  output logic      [WIDTH-1:0] nxtValue
);

  if (WIDTH != 16) begin : g_width_check
    $error("cng_field_reg supports 16-bit registers only");
  end

  logic [WIDTH-1:0] value_ff;

  // Next value: masked write, forced bits always high
  always_comb begin
    nxtValue = value_ff;
    if (wrEn) begin
      nxtValue = (value_ff & ~WR_MASK) | (wrData & WR_MASK);
    end
    nxtValue = nxtValue | FORCE;
  end

  // Storage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      value_ff <= RESET;
    end else begin
      value_ff <= nxtValue;
    end
  end

  assign value = value_ff;

endmodule : cng_field_reg

// file: rtl/cng_negotiation_regs.sv
`timescale 1ns/1ns
// Contract
// - Advertisement bit 15 is one, so gigabit next pages are exchanged.
// - Partner base ability register never takes received next page contents.
// - Transmitter test mode comes from gigabit control bits 15:13.
// - Test mode bits read zero after reset, meaning normal operation.
// - Manual enable bit selects manual master/slave value; resets to zero.
// - When enabled, config value forces master on one, slave on zero.
// - Without manual config, port type gives preference: one master, zero slave.
// - Gigabit full duplex advertised exactly when its control bit is one.
// - Gigabit half duplex advertised exactly when its control bit is one.
// - Device negotiates and can operate as either master or slave.
module cng_negotiation_regs #(
  parameter int ADDR_W = 5
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [15:0]       regWrData,
  output logic      [15:0]       regRdData,
  output logic                   regRdValid,
  input  wire logic [15:0]       basicControl,
  input  wire logic [15:0]       basicStatus,
  input  wire logic [15:0]       negExpansion,
  input  wire logic              partnerPageValid,
  input  wire logic              partnerPageIsNext,
  input  wire logic [15:0]       partnerPageWord,
  output logic      [15:0]       advertWord,
  output logic      [15:0]       nextPageTxWord,
  output logic      [2:0]        testMode,
  output logic                   msForced,
  output logic                   msWantMaster,
  output logic                   advGigFull,
  output logic                   advGigHalf
);

  // Decode slices the low five bits, so a narrower index bus cannot be served
  if (ADDR_W < 5) begin : g_addr_check
    $error("cng_negotiation_regs needs at least five address bits");
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic [4:0] addrLow;
  logic       wrAdvert;
  logic       wrNextPage;
  logic       wrGigCtrl;

  // Upper address bits beyond five must be zero to hit a register
  assign addrLow    = regAddr[4:0];
  assign wrAdvert   = regWrite && (regAddr == ADDR_W'(cng_pkg::REG_NEG_ADVERT));
  assign wrNextPage = regWrite && (regAddr == ADDR_W'(cng_pkg::REG_NEXT_PAGE_TX));
  assign wrGigCtrl  = regWrite && (regAddr == ADDR_W'(cng_pkg::REG_GIGABIT_CTRL));

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  logic [15:0] advertValue;
  logic [15:0] advertNext;
  logic [15:0] nextPageValue;
  logic [15:0] gigValue;
  logic [15:0] gigNext;

  // Selector and technology field contents are software's job; bit 15 held high
  cng_field_reg #(
    .WIDTH   (16),
    .RESET   (cng_pkg::ADV_RESET),
    .WR_MASK (cng_pkg::ADV_WR_MASK),
    .FORCE   (cng_pkg::ADV_FORCE_ONE)
  ) u_advert (
    .clock    (clock),
    .reset_n  (reset_n),
    .wrEn     (wrAdvert),
    .wrData   (regWrData),
    .value    (advertValue),
    .nxtValue (advertNext)
  );

  cng_field_reg #(
    .WIDTH   (16),
    .RESET   (cng_pkg::NPT_RESET),
    .WR_MASK (cng_pkg::NPT_WR_MASK),
    .FORCE   (16'h0000)
  ) u_next_page (
    .clock    (clock),
    .reset_n  (reset_n),
    .wrEn     (wrNextPage),
    .wrData   (regWrData),
    .value    (nextPageValue),
    .nxtValue ()
  );

  // Reserved low byte never stores, so it reads back zero
  cng_field_reg #(
    .WIDTH   (16),
    .RESET   (cng_pkg::GIG_RESET),
    .WR_MASK (cng_pkg::GIG_WR_MASK),
    .FORCE   (16'h0000)
  ) u_gig_ctrl (
    .clock    (clock),
    .reset_n  (reset_n),
    .wrEn     (wrGigCtrl),
    .wrData   (regWrData),
    .value    (gigValue),
    .nxtValue (gigNext)
  );

  // ----------------------------------------------------------------
  // Partner base and next page stores
  // ----------------------------------------------------------------
  logic [15:0] partnerBase_ff;
  logic [15:0] nxt_partnerBase;
  logic [15:0] partnerNext_ff;
  logic [15:0] nxt_partnerNext;

  // Next pages go to their own register so base abilities survive the exchange
  always_comb begin
    nxt_partnerBase = partnerBase_ff;
    nxt_partnerNext = partnerNext_ff;
    if (partnerPageValid && !partnerPageIsNext) begin
      nxt_partnerBase = partnerPageWord;
    end
    if (partnerPageValid && partnerPageIsNext) begin
      nxt_partnerNext = partnerPageWord;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      partnerBase_ff <= cng_pkg::PARTNER_RESET;
      partnerNext_ff <= cng_pkg::PARTNER_RESET;
    end else begin
      partnerBase_ff <= nxt_partnerBase;
      partnerNext_ff <= nxt_partnerNext;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs toward the negotiation and PMA logic
  // ----------------------------------------------------------------
  logic [15:0] advertWord_ff;
  logic [15:0] nextPageTx_ff;
  logic [2:0]  testMode_ff;
  logic        msForced_ff;
  logic        msWantMaster_ff;
  logic        advGigFull_ff;
  logic        advGigHalf_ff;
  logic [15:0] nxt_advertWord;
  logic [2:0]  nxt_testMode;
  logic        nxt_msForced;
  logic        nxt_msWantMaster;
  logic        nxt_advGigFull;
  logic        nxt_advGigHalf;

  // Built from next register values so these outputs line up with the stored fields; nextPageTxWord lags its register by one cycle
  always_comb begin
    nxt_advertWord = advertNext;
    nxt_testMode   = gigNext[cng_pkg::GIG_TEST_MSB:cng_pkg::GIG_TEST_LSB];
    nxt_msForced   = gigNext[cng_pkg::GIG_MANUAL_EN_BIT];
    if (gigNext[cng_pkg::GIG_MANUAL_EN_BIT]) begin
      nxt_msWantMaster = gigNext[cng_pkg::GIG_MANUAL_VAL_BIT];
    end else begin
      nxt_msWantMaster = gigNext[cng_pkg::GIG_PORT_TYPE_BIT];
    end
    nxt_advGigFull = gigNext[cng_pkg::GIG_FULL_BIT];
    nxt_advGigHalf = gigNext[cng_pkg::GIG_HALF_BIT];
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      advertWord_ff   <= cng_pkg::ADV_RESET;
      nextPageTx_ff   <= cng_pkg::NPT_RESET;
      testMode_ff     <= 3'h0;
      msForced_ff     <= 1'b0;
      msWantMaster_ff <= 1'b0;
      advGigFull_ff   <= 1'b0;
      advGigHalf_ff   <= 1'b0;
    end else begin
      advertWord_ff   <= nxt_advertWord;
      nextPageTx_ff   <= nextPageValue;
      testMode_ff     <= nxt_testMode;
      msForced_ff     <= nxt_msForced;
      msWantMaster_ff <= nxt_msWantMaster;
      advGigFull_ff   <= nxt_advGigFull;
      advGigHalf_ff   <= nxt_advGigHalf;
    end
  end

  assign advertWord     = advertWord_ff;
  assign nextPageTxWord = nextPageTx_ff;
  assign testMode       = testMode_ff;
  assign msForced       = msForced_ff;
  assign msWantMaster   = msWantMaster_ff;
  assign advGigFull     = advGigFull_ff;
  assign advGigHalf     = advGigHalf_ff;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] rdData_ff;
  logic        rdValid_ff;
  logic [15:0] nxt_rdData;
  logic        nxt_rdValid;
  logic        addrHigh;

  assign addrHigh = (regAddr != ADDR_W'(addrLow));

  // Pure mux: nothing here changes state, so reads are harmless
  always_comb begin
    nxt_rdValid = regRead;
    nxt_rdData  = rdData_ff;
    if (regRead) begin
      unique case (addrLow)
        cng_pkg::REG_BASIC_CONTROL: nxt_rdData = basicControl;
        cng_pkg::REG_BASIC_STATUS:  nxt_rdData = basicStatus;
        cng_pkg::REG_NEG_ADVERT:    nxt_rdData = advertValue;
        cng_pkg::REG_PARTNER_BASE:  nxt_rdData = partnerBase_ff;
        cng_pkg::REG_NEG_EXPANSION: nxt_rdData = negExpansion;
        cng_pkg::REG_NEXT_PAGE_TX:  nxt_rdData = nextPageValue;
        cng_pkg::REG_PARTNER_NEXT:  nxt_rdData = partnerNext_ff;
        cng_pkg::REG_GIGABIT_CTRL:  nxt_rdData = gigValue;
        default:                    nxt_rdData = cng_pkg::UNMAPPED_READ;
      endcase
      if (addrHigh) begin
        nxt_rdData = cng_pkg::UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdData_ff  <= 16'h0000;
      rdValid_ff <= 1'b0;
    end else begin
      rdData_ff  <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
    end
  end

  assign regRdData  = rdData_ff;
  assign regRdValid = rdValid_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic gigWritten_ff;

  // Remembers whether the gigabit control register was ever written
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gigWritten_ff <= 1'b0;
    end else if (wrGigCtrl) begin
      gigWritten_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence gig_write_s;
    wrGigCtrl ##1 1'b1;
  endsequence

  next_page_bit_a: assert property (advertWord[15] && advertValue[15])
    else $error("advertisement next page bit not one");
  base_keep_a: assert property (partnerPageValid && partnerPageIsNext |=> $stable(partnerBase_ff))
    else $error("partner base ability changed on next page");
  test_mode_wr_a: assert property (gig_write_s |-> testMode == $past(regWrData[15:13]))
    else $error("test mode does not follow write");
  test_mode_rst_a: assert property (!gigWritten_ff |-> testMode == 3'h0)
    else $error("test mode not zero before any write");
  manual_en_a: assert property (msForced == gigValue[12])
    else $error("manual enable output mismatch");
  manual_val_a: assert property (msForced |-> msWantMaster == gigValue[11])
    else $error("forced role does not follow config value");
  port_pref_a: assert property (!msForced |-> msWantMaster == gigValue[10])
    else $error("role preference does not follow port type");
  full_adv_a: assert property (advGigFull == gigValue[9])
    else $error("full duplex advertisement mismatch");
  half_adv_a: assert property (advGigHalf == gigValue[8])
    else $error("half duplex advertisement mismatch");
  role_both_a: assert property (wrGigCtrl && regWrData[12] |=> msWantMaster == $past(regWrData[11]))
    else $error("manual role not applied after write");
  field_hold_a: assert property (!wrGigCtrl |=> $stable(gigValue))
    else $error("gigabit control changed without write");
  read_answer_a: assert property (regRead && regAddr == ADDR_W'(cng_pkg::REG_GIGABIT_CTRL) && !wrGigCtrl
                                  |=> regRdValid && regRdData == gigValue)
    else $error("read answer missing or wrong");

endmodule : cng_negotiation_regs

// file: dv/cng_mgmt_model.sv
`timescale 1ns/1ns
// -------------------------------------------------------------
// Management station model: one request at a time
// -------------------------------------------------------------
module cng_mgmt_model #(
  parameter logic [4:0] SELECTOR_CODE = 5'h01  // Protocol family code, plain default
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  output logic      [4:0]  regAddr,
  output logic             regWrite,
  output logic             regRead,
  output logic      [15:0] regWrData,
  input  wire logic [15:0] regRdData,
  input  wire logic        regRdValid
);
  // Idle lines at time zero, nothing requested
  initial begin
    regAddr   = 5'h1F;
    regWrite  = 1'h0;
    regRead   = 1'h0;
    regWrData = 16'hA5A5;
  end

  // Write strobe held one cycle; released lines show inverted data
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'h1;
    @(posedge clock);
    regWrite  <= 1'h0;
    regAddr   <= ~a;
    regWrData <= ~d;
  endtask : wr

  // Read strobe held one cycle; data taken at the rising edge where valid is sampled high
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output int lat);
    d   = 16'hXXXX;
    lat = -1;
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clock);
    regRead <= 1'h0;
    regAddr <= ~a;
    for (int i = 1; i < 5; i++) begin
      @(posedge clock);
      if (regRdValid === 1'h1) begin
        d   = regRdData;
        lat = i;
        break;
      end
    end
  endtask : rd

  // Advertisement built with selector, ability code and next-page bit set
  task automatic load_advert(input logic [7:0] tech);
    wr(cng_pkg::REG_NEG_ADVERT, {1'h1, 2'h0, tech, SELECTOR_CODE});
  endtask : load_advert
endmodule : cng_mgmt_model

// file: dv/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
  // -------------------------------------------------------------
  // Signals and reference state
  // -------------------------------------------------------------
  logic        clock, reset_n, regWrite, regRead, regRdValid;
  logic [4:0]  regAddr;
  logic [15:0] regWrData, regRdData, basicControl, basicStatus, negExpansion;
  logic        partnerPageValid, partnerPageIsNext, msForced, msWantMaster, advGigFull, advGigHalf;
  logic [15:0] partnerPageWord, advertWord, nextPageTxWord, lfsr, advM, npM, gigM, baseM, nextM, d, w;
  logic [2:0]  testMode;
  int          errors, samplesChecked, lat;
  logic [15:0] gigCorner [6] = '{16'hFFFF, 16'h0000, 16'h1800, 16'h1400, 16'h0400, 16'hE0FF};

  cng_negotiation_regs #(.ADDR_W(5)) u_cng_negotiation_regs (.clock(clock), .reset_n(reset_n),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .basicControl(basicControl),
    .basicStatus(basicStatus), .negExpansion(negExpansion), .partnerPageValid(partnerPageValid),
    .partnerPageIsNext(partnerPageIsNext), .partnerPageWord(partnerPageWord),
    .advertWord(advertWord), .nextPageTxWord(nextPageTxWord), .testMode(testMode),
    .msForced(msForced), .msWantMaster(msWantMaster), .advGigFull(advGigFull), .advGigHalf(advGigHalf));
  cng_mgmt_model u_cng_mgmt_model (.clock(clock), .reset_n(reset_n), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid));

  // -------------------------------------------------------------
  // Clock, random source and expectation helpers
  // -------------------------------------------------------------
  always #5 clock = ~clock;

  function automatic logic [15:0] rand16();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rand16

  // Manual value wins only while manual enable is set
  function automatic logic expMaster(input logic [15:0] g);
    return g[12] ? g[11] : g[10];
  endfunction : expMaster

  function automatic logic [15:0] expRead(input logic [4:0] a);
    case (a)
      5'h00:   return basicControl;
      5'h01:   return basicStatus;
      5'h04:   return advM;
      5'h05:   return baseM;
      5'h06:   return negExpansion;
      5'h07:   return npM;
      5'h08:   return nextM;
      5'h09:   return gigM;
      default: return cng_pkg::UNMAPPED_READ;
    endcase
  endfunction : expRead

  task automatic resetModel();
    advM  = cng_pkg::ADV_RESET;
    npM   = cng_pkg::NPT_RESET;
    gigM  = cng_pkg::GIG_RESET;
    baseM = cng_pkg::PARTNER_RESET;
    nextM = cng_pkg::PARTNER_RESET;
  endtask : resetModel

  task automatic chkOut();
    `CHK("testMode", gigM[15:13], testMode)
    `CHK("msForced", gigM[12], msForced)
    `CHK("msWantMaster", expMaster(gigM), msWantMaster)
    `CHK("advGigFull", gigM[9], advGigFull)
    `CHK("advGigHalf", gigM[8], advGigHalf)
    `CHK("advertWord", advM, advertWord)
    `CHK("nextPageTxWord", npM, nextPageTxWord)
  endtask : chkOut

  // Reads indexes 0 to 10 and 31 twice; the second read proves reads leave no trace
  task automatic sweep();
    for (int a = 0; a < 12; a++) begin
      for (int k = 0; k < 2; k++) begin
        u_cng_mgmt_model.rd(5'(a == 11 ? 31 : a), d, lat);
        `CHK("readData", expRead(5'(a == 11 ? 31 : a)), d)
        `CHK("readLatency", 1, lat)
      end
    end
    chkOut();
  endtask : sweep

  task automatic page(input logic isNext, input logic [15:0] word);
    partnerPageValid  <= 1'h1;
    partnerPageIsNext <= isNext;
    partnerPageWord   <= word;
    if (isNext) nextM = word;
    else baseM = word;
    @(posedge clock);
  endtask : page

  task automatic test_done();
    $display("Checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // -------------------------------------------------------------
  // Watchdog at 20000 cycles, far above the few hundred cycles the tests need
  // -------------------------------------------------------------
  initial begin
    #200000;
    errors++;
    test_done();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    clock = 1'h0; reset_n = 1'h0; lfsr = 16'hEE7B; errors = 0; samplesChecked = 0;
    basicControl = 16'h1140; basicStatus = 16'h7949; negExpansion = 16'h0004;
    partnerPageValid = 1'h0; partnerPageIsNext = 1'h0; partnerPageWord = 16'h0000;
    resetModel();
    repeat (20) @(posedge clock);
    reset_n <= 1'h1;
    // Reset values and external words
    basicControl <= rand16(); basicStatus <= rand16(); negExpansion <= rand16();
    u_cng_mgmt_model.rd(cng_pkg::REG_GIGABIT_CTRL, d, lat);
    `CHK("gigReset", 16'h0000, d)
    sweep();
    $display("Test 1 done");
    // Gigabit control: corner words, then random words
    for (int i = 0; i < 30; i++) begin
      w = (i < 6) ? gigCorner[i] : rand16();
      u_cng_mgmt_model.wr(cng_pkg::REG_GIGABIT_CTRL, w);
      gigM = w & cng_pkg::GIG_WR_MASK;
      @(negedge clock);
      chkOut();
      u_cng_mgmt_model.rd(cng_pkg::REG_GIGABIT_CTRL, d, lat);
      `CHK("gigRead", gigM, d)
    end
    $display("Test 2 done");
    // Advertisement: next-page bit cannot be cleared
    u_cng_mgmt_model.wr(cng_pkg::REG_NEG_ADVERT, 16'h7FFF);
    advM = 16'hFFFF;
    sweep();
    w = rand16();
    u_cng_mgmt_model.load_advert(w[7:0]);
    advM = {1'h1, 2'h0, w[7:0], u_cng_mgmt_model.SELECTOR_CODE};
    u_cng_mgmt_model.wr(cng_pkg::REG_NEXT_PAGE_TX, w);
    npM = w;
    sweep();
    $display("Test 3 done");
    // Partner pages back to back: base page kept apart from next page
    @(posedge clock);
    page(1'h0, rand16());
    page(1'h1, rand16());
    page(1'h1, rand16());
    partnerPageValid <= 1'h0;
    partnerPageWord  <= ~partnerPageWord;
    u_cng_mgmt_model.rd(cng_pkg::REG_PARTNER_BASE, d, lat);
    `CHK("baseAbility", baseM, d)
    sweep();
    $display("Test 4 done");
    // Writes to read-only and unmapped indexes change nothing
    foreach (gigCorner[i]) u_cng_mgmt_model.wr(5'(i == 4 ? 5 : i == 5 ? 8 : i), rand16());
    sweep();
    $display("Test 5 done");
    // Second reset in mid-run restores every default
    @(posedge clock);
    reset_n <= 1'h0;
    repeat (2) @(posedge clock);
    reset_n <= 1'h1;
    resetModel();
    @(negedge clock);
    chkOut();
    sweep();
    $display("Test 6 done");
    test_done();
  end
endmodule : testbench
